// ==== src/ptt_pkg.sv ====
// Constants and types for the precision time stamp timer
package ptt_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_INC = 8'h00;
    localparam logic [7:0] OFS_SUBNS = 8'h04;
    localparam logic [7:0] OFS_CMP_NS = 8'h08;
    localparam logic [7:0] OFS_CMP_SL = 8'h0C;
    localparam logic [7:0] OFS_CMP_SH = 8'h10;
    localparam logic [7:0] OFS_TIM_NS = 8'h14;
    localparam logic [7:0] OFS_TIM_SL = 8'h18;
    localparam logic [7:0] OFS_TIM_SH = 8'h1C;
    localparam logic [7:0] OFS_ISTS = 8'h20;
    localparam logic [7:0] OFS_ICLR = 8'h24;
    localparam logic [7:0] OFS_IEN = 8'h28;
    // Capture i at OFS_CAP + i*CAP_STRIDE; words ns, sec low, sec high
    localparam logic [7:0] OFS_CAP = 8'h40;
    localparam int CAP_STRIDE_LSB = 4;
    localparam logic [1:0] CAP_W_NS = 2'h0;
    localparam logic [1:0] CAP_W_SL = 2'h1;
    localparam logic [1:0] CAP_W_SH = 2'h2;

    // ----------------------------------------------------------------
    // Field layouts and widths
    // ----------------------------------------------------------------
    localparam int FLD_W = 8;
    localparam int INC_DEF_LSB = 0;
    localparam int INC_ALT_LSB = 8;
    localparam int INC_NUM_LSB = 16;
    localparam int SUBNS_W = 16;
    localparam int NS_W = 30;
    localparam int SEC_W = 48;
    localparam int SEC_LO_W = 32;
    localparam int SEC_HI_W = 16;
    localparam int CMP_NS_W = 22;
    localparam int CMP_NS_LSB = NS_W - CMP_NS_W;
    localparam int IRQ_CMP_BIT = 29;
    localparam logic [29:0] NS_PER_SEC = 30'h3B9A_CA00;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [47:0] sec;
        logic [31:0] ns;
    } ptt_ts_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ptt_bus_req_t;

endpackage

// ==== src/ptt_timer.sv ====
// Precision time stamp timer with captures, compare and interrupt
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns

module ptt_timer #(
    parameter int N_CAP = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire ptt_pkg::ptt_bus_req_t bus_req,
    output logic [31:0] rd_data,
    // Frame event capture strobes, one per capture register
    input wire logic [N_CAP-1:0] cap_stb,
    // Outputs
    output logic timer_compare_match,
    output logic irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [31:0] timer_increment_ff;
    logic [15:0] subns_increment_ff;
    logic [21:0] compare_nanoseconds_ff;
    logic [31:0] compare_seconds_low_ff;
    logic [15:0] compare_seconds_high_ff;
    logic [31:0] int_en_ff;
    logic [31:0] int_sts_ff;
    logic [31:0] rd_data_ff;
    logic [29:0] ns_ff;
    logic [47:0] sec_ff;
    logic [15:0] subns_acc_ff;
    logic [7:0] alt_cnt_ff;
    logic match_ff;
    ptt_pkg::ptt_ts_t cap_ff [N_CAP];

    // Address match used by every register except the captures
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire [7:0] addr = bus_req.addr;
    wire wr = bus_req.wr;
    wire [31:0] wd = bus_req.wdata;
    wire wr_inc = wr && hit(addr, ptt_pkg::OFS_INC);
    wire wr_sub = wr && hit(addr, ptt_pkg::OFS_SUBNS);
    wire wr_cns = wr && hit(addr, ptt_pkg::OFS_CMP_NS);
    wire wr_csl = wr && hit(addr, ptt_pkg::OFS_CMP_SL);
    wire wr_csh = wr && hit(addr, ptt_pkg::OFS_CMP_SH);
    wire wr_clr = wr && hit(addr, ptt_pkg::OFS_ICLR);
    wire wr_ien = wr && hit(addr, ptt_pkg::OFS_IEN);
    wire [7:0] cap_off = addr - ptt_pkg::OFS_CAP;
    wire [7:0] cap_idx = 8'(cap_off >> ptt_pkg::CAP_STRIDE_LSB);
    wire cap_in = (addr >= ptt_pkg::OFS_CAP) && (cap_idx < 8'(N_CAP));
    wire [1:0] cap_wsel = cap_off[3:2];

    // ----------------------------------------------------------------
    // Increment selection
    // ----------------------------------------------------------------
    wire [7:0] def_inc = timer_increment_ff[ptt_pkg::INC_DEF_LSB +: ptt_pkg::FLD_W];
    wire [7:0] alt_inc = timer_increment_ff[ptt_pkg::INC_ALT_LSB +: ptt_pkg::FLD_W];
    wire [7:0] num_inc = timer_increment_ff[ptt_pkg::INC_NUM_LSB +: ptt_pkg::FLD_W];
    // Alternative step after num_inc default steps; never when zero
    wire alt_due = (num_inc != 8'h00) && (alt_cnt_ff >= num_inc);
    wire [7:0] step_ns = alt_due ? alt_inc : def_inc;
    wire [7:0] nxt_alt_cnt = alt_due ? 8'h00 : 8'(alt_cnt_ff + 8'h01);

    // Fraction accumulator; its carry adds one nanosecond
    wire [16:0] sub_sum = {1'b0, subns_acc_ff} + {1'b0, subns_increment_ff};
    wire [15:0] nxt_subns_acc = sub_sum[15:0];
    wire [29:0] ns_sum = ns_ff + 30'(step_ns) + 30'(sub_sum[16]);

    // Nanosecond rollover into seconds
    wire ns_wrap = (ns_sum >= ptt_pkg::NS_PER_SEC);
    wire [29:0] nxt_ns = ns_wrap ? 30'(ns_sum - ptt_pkg::NS_PER_SEC) : ns_sum;
    wire [47:0] nxt_sec = sec_ff + 48'(ns_wrap);

    // ----------------------------------------------------------------
    // Compare and events
    // ----------------------------------------------------------------
    wire [47:0] cmp_sec = {compare_seconds_high_ff, compare_seconds_low_ff};
    wire cmp_eq = (sec_ff == cmp_sec)
        && (ns_ff[ptt_pkg::CMP_NS_LSB +: ptt_pkg::CMP_NS_W] == compare_nanoseconds_ff);
    wire cmp_rise = cmp_eq && !match_ff;
    wire [31:0] ev = (32'(cmp_rise) << ptt_pkg::IRQ_CMP_BIT) | 32'(cap_stb);
    // Hardware set wins over a clear in the same cycle
    wire [31:0] clr = wr_clr ? wd : ptt_pkg::RST_WORD;
    wire [31:0] nxt_int_sts = (int_sts_ff & ~clr) | ev;
    wire ptt_pkg::ptt_ts_t cur_ts = '{sec: sec_ff, ns: 32'(ns_ff)};

    // ----------------------------------------------------------------
    // Read selection
    // ----------------------------------------------------------------
    wire ptt_pkg::ptt_ts_t cap_rd = cap_in ? cap_ff[cap_idx[2:0]] : '0;
    wire [31:0] cap_word =
        (cap_wsel == ptt_pkg::CAP_W_NS) ? cap_rd.ns :
        (cap_wsel == ptt_pkg::CAP_W_SL) ? cap_rd.sec[31:0] :
        (cap_wsel == ptt_pkg::CAP_W_SH) ? 32'(cap_rd.sec[47:32]) : 32'h0000_0000;
    wire [31:0] nxt_rd_data =
        hit(addr, ptt_pkg::OFS_INC) ? timer_increment_ff :
        hit(addr, ptt_pkg::OFS_SUBNS) ? 32'(subns_increment_ff) :
        hit(addr, ptt_pkg::OFS_CMP_NS) ? 32'(compare_nanoseconds_ff) :
        hit(addr, ptt_pkg::OFS_CMP_SL) ? compare_seconds_low_ff :
        hit(addr, ptt_pkg::OFS_CMP_SH) ? 32'(compare_seconds_high_ff) :
        hit(addr, ptt_pkg::OFS_TIM_NS) ? 32'(ns_ff) :
        hit(addr, ptt_pkg::OFS_TIM_SL) ? sec_ff[31:0] :
        hit(addr, ptt_pkg::OFS_TIM_SH) ? 32'(sec_ff[47:32]) :
        hit(addr, ptt_pkg::OFS_ISTS) ? int_sts_ff :
        hit(addr, ptt_pkg::OFS_IEN) ? int_en_ff :
        cap_in ? cap_word : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timer_increment_ff <= ptt_pkg::RST_WORD;
            subns_increment_ff <= ptt_pkg::RST_WORD[15:0];
            compare_nanoseconds_ff <= ptt_pkg::RST_WORD[21:0];
            compare_seconds_low_ff <= ptt_pkg::RST_WORD;
            compare_seconds_high_ff <= ptt_pkg::RST_WORD[15:0];
            int_en_ff <= ptt_pkg::RST_WORD;
        end else begin
            if (wr_inc) timer_increment_ff <= wd;
            if (wr_sub) subns_increment_ff <= wd[15:0];
            if (wr_cns) compare_nanoseconds_ff <= wd[21:0];
            if (wr_csl) compare_seconds_low_ff <= wd;
            if (wr_csh) compare_seconds_high_ff <= wd[15:0];
            if (wr_ien) int_en_ff <= wd;
        end
    end

    // Read data, interrupt status and compare match
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_ff <= ptt_pkg::RST_WORD;
            int_sts_ff <= ptt_pkg::RST_WORD;
            match_ff <= 1'b0;
        end else begin
            rd_data_ff <= bus_req.rd ? nxt_rd_data : ptt_pkg::RST_WORD;
            int_sts_ff <= nxt_int_sts;
            match_ff <= cmp_eq;
        end
    end

    // Running time
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ns_ff <= ptt_pkg::RST_WORD[29:0];
            sec_ff <= 48'h0000_0000_0000;
            subns_acc_ff <= ptt_pkg::RST_WORD[15:0];
            alt_cnt_ff <= ptt_pkg::RST_WORD[7:0];
        end else begin
            ns_ff <= nxt_ns;
            sec_ff <= nxt_sec;
            subns_acc_ff <= nxt_subns_acc;
            alt_cnt_ff <= nxt_alt_cnt;
        end
    end

    // Capture registers, one per event strobe
    for (genvar gi = 0; gi < N_CAP; gi++) begin : g_cap
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                cap_ff[gi] <= '0;
            end else if (cap_stb[gi]) begin
                cap_ff[gi] <= cur_ts;
            end
        end
    end

    assign rd_data = rd_data_ff;
    assign timer_compare_match = match_ff;
    assign irq = |(int_sts_ff & int_en_ff);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_def_step;
        (timer_increment_ff[23:8] == 16'h0000) && (subns_increment_ff == 16'h0000)
            && !ns_wrap && !wr_inc |=> ns_ff == $past(ns_ff) + 30'($past(def_inc));
    endproperty
    a_def_step: assert property (p_def_step) else $error("default step wrong");

    property p_frac;
        !wr_sub |=> subns_acc_ff == 16'($past(subns_acc_ff) + $past(subns_increment_ff));
    endproperty
    a_frac: assert property (p_frac) else $error("fraction accumulate wrong");

    property p_plain;
        (timer_increment_ff[23:8] == 16'h0000) && !ns_wrap |=>
            ns_ff == $past(ns_ff) + 30'($past(def_inc)) + 30'($past(sub_sum[16]));
    endproperty
    a_plain: assert property (p_plain) else $error("plain increment wrong");

    sequence s_alt_step;
        alt_due && !ns_wrap && !wr_inc ##1 alt_cnt_ff == 8'h00;
    endsequence
    property p_alt;
        s_alt_step |-> ns_ff == $past(ns_ff) + 30'($past(alt_inc)) + 30'($past(sub_sum[16]));
    endproperty
    a_alt: assert property (p_alt) else $error("alternative step wrong");

    property p_no_alt;
        (num_inc == 8'h00) |-> step_ns == def_inc;
    endproperty
    a_no_alt: assert property (p_no_alt) else $error("alternative used with zero count");

    property p_cap;
        cap_stb[0] |=> cap_ff[0] == $past(cur_ts);
    endproperty
    a_cap: assert property (p_cap) else $error("capture not latched");

    property p_cap_irq;
        cap_stb[0] |=> int_sts_ff[0] [*2];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture flag lost");

    property p_cmp;
        (sec_ff == cmp_sec) && (ns_ff[29:8] == compare_nanoseconds_ff)
            |=> timer_compare_match;
    endproperty
    a_cmp: assert property (p_cmp) else $error("match not seen");

    property p_cmp_reg;
        wr_cns |=> compare_nanoseconds_ff == $past(wd[21:0]);
    endproperty
    a_cmp_reg: assert property (p_cmp_reg) else $error("compare register not written");

    property p_match;
        timer_compare_match |-> $past(cmp_eq);
    endproperty
    a_match: assert property (p_match) else $error("spurious match");

    sequence s_cmp_hit;
        cmp_rise ##1 int_en_ff[29];
    endsequence
    property p_cmp_irq;
        s_cmp_hit |-> int_sts_ff[29] && irq;
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare interrupt missing");

    property p_wrap;
        ns_wrap |=> (sec_ff == $past(sec_ff) + 48'h0000_0000_0001)
            && (ns_ff < ptt_pkg::NS_PER_SEC);
    endproperty
    a_wrap: assert property (p_wrap) else $error("seconds rollover wrong");

endmodule

// ==== test/test_ptp_timestamp_timer.sv ====
// Self-checking bench for the precision time stamp timer
`timescale 1ns/1ns

module test_ptp_timestamp_timer;
    // ----------------------------------------------------------------
    // Signals and instance
    // ----------------------------------------------------------------
    logic sys_clk;
    logic rstn;
    ptt_pkg::ptt_bus_req_t bus_req;
    logic [31:0] rd_data;
    logic [7:0] cap_stb;
    logic timer_compare_match;
    logic irq;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] v;
    logic [31:0] n;
    // Increment words, spans in cycles and expected ns advance
    logic [31:0] inc_tab [4] = '{32'h0000_000A, 32'h0032_6462, 32'h00F8_2814, 32'h0000_6462};
    int len_tab [4] = '{20, 51, 249, 51};
    logic [31:0] adv_tab [4] = '{32'h0000_00C8, 32'h0000_1388, 32'h0000_1388, 32'h0000_1386};

    ptt_timer #(.N_CAP(8)) u_dut (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .cap_stb(cap_stb),
        .timer_compare_match(timer_compare_match),
        .irq(irq)
    );

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Compare, bus and closing tasks
    // ----------------------------------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        @(posedge sys_clk);
        d = rd_data;
    endtask

    // Time advance over s cycles, taken from two reads s cycles apart
    task automatic span(input int s, output logic [31:0] d);
        logic [31:0] a;
        logic [31:0] b;
        rd(ptt_pkg::OFS_TIM_NS, a);
        repeat (s - 3) @(posedge sys_clk);
        rd(ptt_pkg::OFS_TIM_NS, b);
        d = b - a;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        rd(ptt_pkg::OFS_INC, v);
        chk32(v, 32'h0000_0000);
        rd(ptt_pkg::OFS_TIM_NS, v);
        chk32(v, 32'h0000_0000);
        rd(8'h30, v);
        chk32(v, 32'h0000_0000);
        chk1(irq, 1'b0);
        // Time 0.0 equals the cleared compare value, so match is up at once
        chk1(timer_compare_match, 1'b1);
        rd(ptt_pkg::OFS_ISTS, v);
        chk32(v, 32'h2000_0000);
        wr(ptt_pkg::OFS_ICLR, 32'h2000_0000);
        rd(ptt_pkg::OFS_ISTS, v);
        chk32(v, 32'h0000_0000);
    endtask

    task automatic test_steps;
        wr(ptt_pkg::OFS_INC, 32'h0000_000A);
        wr(ptt_pkg::OFS_SUBNS, 32'h0000_8000);
        span(20, v);
        chk32(v, 32'h0000_00D2);
        wr(ptt_pkg::OFS_SUBNS, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(ptt_pkg::OFS_INC, inc_tab[i]);
            span(len_tab[i], v);
            chk32(v, adv_tab[i]);
        end
    endtask

    // Capture together with a time read at the same edge
    task automatic cap_one(input int i);
        logic [31:0] t;
        @(posedge sys_clk);
        cap_stb <= 8'h01 << i;
        bus_req.addr <= ptt_pkg::OFS_TIM_NS;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        cap_stb <= 8'h00;
        bus_req.rd <= 1'b0;
        @(posedge sys_clk);
        t = rd_data;
        rd(ptt_pkg::OFS_CAP + 8'(i * 16), v);
        chk32(v, t);
        rd(ptt_pkg::OFS_CAP + 8'(i * 16 + 4), v);
        chk32(v, 32'h0000_0000);
        rd(ptt_pkg::OFS_ISTS, v);
        chk32(v, 32'h1 << i);
        chk1(irq, i[0]);
        wr(ptt_pkg::OFS_ICLR, 32'h1 << i);
        rd(ptt_pkg::OFS_ISTS, v);
        chk32(v, 32'h0000_0000);
        chk1(irq, 1'b0);
    endtask

    task automatic test_capture;
        wr(ptt_pkg::OFS_INC, 32'h0000_000A);
        wr(ptt_pkg::OFS_IEN, 32'h0000_00AA);
        for (int i = 0; i < 8; i++) begin
            cap_one(i);
        end
    endtask

    // Frozen timer, compare armed by the high seconds word
    task automatic test_compare;
        wr(ptt_pkg::OFS_INC, 32'h0000_0000);
        rd(ptt_pkg::OFS_TIM_NS, n);
        rd(ptt_pkg::OFS_TIM_SL, v);
        chk32(v, 32'h0000_0000);
        wr(ptt_pkg::OFS_TIM_NS, ~n);
        rd(ptt_pkg::OFS_TIM_NS, v);
        chk32(v, n);
        wr(ptt_pkg::OFS_CMP_SH, 32'h0000_0001);
        wr(ptt_pkg::OFS_CMP_SL, 32'h0000_0000);
        wr(ptt_pkg::OFS_CMP_NS, {10'h000, n[29:8]});
        wr(ptt_pkg::OFS_IEN, 32'h2000_0000);
        rd(ptt_pkg::OFS_CMP_NS, v);
        chk32(v, {10'h000, n[29:8]});
        chk1(timer_compare_match, 1'b0);
        wr(ptt_pkg::OFS_CMP_SH, 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        chk1(timer_compare_match, 1'b1);
        chk1(irq, 1'b1);
        rd(ptt_pkg::OFS_ISTS, v);
        chk32(v, 32'h2000_0000);
        wr(ptt_pkg::OFS_ICLR, 32'h2000_0000);
        rd(ptt_pkg::OFS_ISTS, v);
        chk32(v, 32'h0000_0000);
        chk1(irq, 1'b0);
        wr(ptt_pkg::OFS_CMP_NS, {10'h000, n[29:8] + 22'h00_0001});
        repeat (3) @(posedge sys_clk);
        chk1(timer_compare_match, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        bus_req = '0;
        cap_stb = 8'h00;
        rstn = 1'b0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        test_reset;
        test_steps;
        test_capture;
        test_compare;
        report_and_stop;
    end

    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        report_and_stop;
    end
endmodule
